// File: adu_pkg.sv
/*
 * Package for the alert driven output update block: register offsets, reset values,
 * pin mode encodings and the carrier structs shared by the block's modules.
 * Assumes an 8-bit register port with 8-bit addresses inside the device.
 */
package adu_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    localparam logic [7:0] ADU_OFS_UPDATE_ENABLE = 8'he9;
    localparam logic [7:0] ADU_OFS_PRESET_VALUE  = 8'heb;
    localparam logic [7:0] ADU_OFS_OUT7_SRC_MASK = 8'hd1;
    localparam logic [7:0] ADU_OFS_PIN_MODE_LO   = 8'h40;
    localparam logic [7:0] ADU_OFS_PIN_MODE_HI   = 8'h41;
    localparam logic [7:0] ADU_OFS_OUTPUT_VALUE  = 8'h42;
    localparam logic [7:0] ADU_OFS_INPUT_LEVEL   = 8'h43;

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic [7:0]  ADU_RST_UPDATE_ENABLE = 8'h00;
    localparam logic [7:0]  ADU_RST_PRESET_VALUE  = 8'h00;
    localparam logic [7:0]  ADU_RST_OUT7_SRC_MASK = 8'h00;
    localparam logic [15:0] ADU_RST_PIN_MODE      = 16'h0000;
    localparam logic [7:0]  ADU_RST_OUTPUT_VALUE  = 8'h00;

    // Index of the output whose trigger mask this block owns.
    localparam int ADU_OUT7_IDX = 7;

    // =====================================================================
    // Types
    // =====================================================================
    typedef enum logic [1:0] {
        ADU_MODE_INPUT     = 2'b00,
        ADU_MODE_OPEN_DRN  = 2'b01,
        ADU_MODE_PUSH_PULL = 2'b10,
        ADU_MODE_RSVD      = 2'b11
    } adu_mode_t;

    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } adu_reg_req_t;

    typedef struct packed {
        logic [7:0] level;
        logic [7:0] outEnN;
    } adu_pin_drv_t;

endpackage

// File: adu_pin_driver.sv
/*
 * Per-pin driver: turns the mode and output level of each channel into pin level
 * and active-low output enable. Assumes the pad resolves the wire from these.
 */
`timescale 1ns/1ps
module adu_pin_driver #(
    parameter int NPINS = 8                           // Channel count.
) (
    input  wire logic               clock,            // System clock.
    input  wire logic               rst_n,            // Synchronous reset, active low.
    input  wire logic [2*NPINS-1:0] pinMode,          // Two mode bits per pin.
    input  wire logic [NPINS-1:0]   outLevel,         // Level the output wants.
    output adu_pkg::adu_pin_drv_t   drv               // Registered pin drive.
);

    // =====================================================================
    // Drive per pin
    // =====================================================================
    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : gPin
            logic [1:0] mode;
            assign mode = pinMode[2*g +: 2];
            // Reserved mode acts like input so a bad write never fights the pad.
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    drv.level[g]  <= 1'b0;
                    drv.outEnN[g] <= 1'b1;
                end else begin
                    unique case (mode)
                        adu_pkg::ADU_MODE_OPEN_DRN: begin
                            drv.level[g]  <= 1'b0;
                            drv.outEnN[g] <= outLevel[g];
                        end
                        adu_pkg::ADU_MODE_PUSH_PULL: begin
                            drv.level[g]  <= outLevel[g];
                            drv.outEnN[g] <= 1'b0;
                        end
                        default: begin
                            drv.level[g]  <= 1'b0;
                            drv.outEnN[g] <= 1'b1;
                        end
                    endcase
                end
            end
        end
    endgenerate

endmodule // adu_pin_driver

// File: adu_trigger.sv
/*
 * Trigger detector: finds the rising edge of each output's selected alert flags.
 * Assumes alert flags are levels synchronous to the clock.
 */
`timescale 1ns/1ps
module adu_trigger #(
    parameter int NPINS = 8                           // Channel count.
) (
    input  wire logic               clock,            // System clock.
    input  wire logic               rst_n,            // Synchronous reset, active low.
    input  wire logic [NPINS-1:0]   alertFlags,       // Per-channel alert flags.
    input  wire logic [NPINS*NPINS-1:0] srcMask,      // Source mask per output.
    output logic      [NPINS-1:0]   trigPulse         // One-cycle trigger per output.
);

    logic [NPINS-1:0] hit;
    logic [NPINS-1:0] hit_r;

    // =====================================================================
    // Selection and edge
    // =====================================================================
    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : gOut
            assign hit[g] = |(alertFlags & srcMask[g*NPINS +: NPINS]);
        end
    endgenerate

    // Edge detect, so a flag that stays set fires once rather than pinning the pin.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hit_r <= '0;
        end else begin
            hit_r <= hit;
        end
    end

    assign trigPulse = hit & ~hit_r;

endmodule // adu_trigger

// File: adu_output_update.sv
/*
 * Alert driven output update: register file, alert triggered output presets and
 * pin drive for eight shared channel pins.
 * Assumes a simple synchronous register port and alert flags from the comparator;
 * trigger masks of outputs 0 to 6 arrive as inputs from elsewhere in the device.
 */
`timescale 1ns/1ps
module adu_output_update #(
    parameter int NPINS = 8                           // Channel count.
) (
    input  wire logic                 clock,          // System clock, 125 MHz.
    input  wire logic                 rst_n,          // Synchronous reset, active low.
    input  adu_pkg::adu_reg_req_t     regReq,         // Register read or write request.
    output logic [7:0]                regRdData_r,    // Registered read data.
    output logic                      regRdValid_r,   // Read data valid pulse.
    input  wire logic [NPINS-1:0]     alertFlags,     // Alert flags per channel.
    input  wire logic [7*NPINS-1:0]   otherSrcMask,   // Trigger masks for outputs 0..6.
    input  wire logic [NPINS-1:0]     pinIn,          // Pad input levels.
    output logic [NPINS-1:0]          pinOut,         // Pad output levels.
    output logic [NPINS-1:0]          pinOutEn_n      // Pad output enable, active low.
);

    // =====================================================================
    // Registers
    // =====================================================================
    logic [7:0]         updEnable_r;
    logic [7:0]         presetVal_r;
    logic [7:0]         out7Mask_r;
    logic [15:0]        pinMode_r;
    logic [NPINS-1:0]   outValue_r;
    logic [NPINS-1:0]   outValue_nxt;
    logic [NPINS-1:0]   inLevel_r;
    logic [NPINS-1:0]   trigPulse;
    logic [NPINS*NPINS-1:0] srcMask;
    adu_pkg::adu_pin_drv_t drv;

    function automatic logic isInput(input logic [1:0] m);
        isInput = (m == adu_pkg::ADU_MODE_INPUT) || (m == adu_pkg::ADU_MODE_RSVD);
    endfunction

    // Configuration registers written by software.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            updEnable_r <= adu_pkg::ADU_RST_UPDATE_ENABLE;
            presetVal_r <= adu_pkg::ADU_RST_PRESET_VALUE;
            out7Mask_r  <= adu_pkg::ADU_RST_OUT7_SRC_MASK;
            pinMode_r   <= adu_pkg::ADU_RST_PIN_MODE;
        end else if (regReq.wrEn) begin
            unique case (regReq.addr)
                adu_pkg::ADU_OFS_UPDATE_ENABLE: updEnable_r <= regReq.wrData;
                adu_pkg::ADU_OFS_PRESET_VALUE:  presetVal_r <= regReq.wrData;
                adu_pkg::ADU_OFS_OUT7_SRC_MASK: out7Mask_r  <= regReq.wrData;
                adu_pkg::ADU_OFS_PIN_MODE_LO:   pinMode_r[7:0]  <= regReq.wrData;
                adu_pkg::ADU_OFS_PIN_MODE_HI:   pinMode_r[15:8] <= regReq.wrData;
                default: ;
            endcase
        end
    end

    // =====================================================================
    // Trigger and output value
    // =====================================================================
    assign srcMask = {out7Mask_r, otherSrcMask};

    adu_trigger #(.NPINS(NPINS)) uTrig (
        .clock      (clock),
        .rst_n      (rst_n),
        .alertFlags (alertFlags),
        .srcMask    (srcMask),
        .trigPulse  (trigPulse)
    );

    // A trigger in the same cycle as a software write wins, so the alert is not lost.
    always_comb begin
        outValue_nxt = outValue_r;
        if (regReq.wrEn && regReq.addr == adu_pkg::ADU_OFS_OUTPUT_VALUE) begin
            outValue_nxt = regReq.wrData[NPINS-1:0];
        end
        for (int i = 0; i < NPINS; i++) begin
            if (trigPulse[i] && updEnable_r[i]) begin
                outValue_nxt[i] = presetVal_r[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            outValue_r <= adu_pkg::ADU_RST_OUTPUT_VALUE[NPINS-1:0];
        end else begin
            outValue_r <= outValue_nxt;
        end
    end

    // =====================================================================
    // Pins
    // =====================================================================
    adu_pin_driver #(.NPINS(NPINS)) uDrv (
        .clock    (clock),
        .rst_n    (rst_n),
        .pinMode  (pinMode_r),
        .outLevel (outValue_nxt),
        .drv      (drv)
    );

    assign pinOut     = drv.level;
    assign pinOutEn_n = drv.outEnN;

    // Input levels are sampled only for input and reserved pins; output pins read zero.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            inLevel_r <= '0;
        end else begin
            for (int i = 0; i < NPINS; i++) begin
                inLevel_r[i] <= isInput(pinMode_r[2*i +: 2]) & pinIn[i];
            end
        end
    end

    // =====================================================================
    // Read port
    // =====================================================================
    // Unmapped addresses read zero.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            regRdData_r  <= 8'h00;
            regRdValid_r <= 1'b0;
        end else begin
            regRdValid_r <= regReq.rdEn;
            if (regReq.rdEn) begin
                unique case (regReq.addr)
                    adu_pkg::ADU_OFS_UPDATE_ENABLE: regRdData_r <= updEnable_r;
                    adu_pkg::ADU_OFS_PRESET_VALUE:  regRdData_r <= presetVal_r;
                    adu_pkg::ADU_OFS_OUT7_SRC_MASK: regRdData_r <= out7Mask_r;
                    adu_pkg::ADU_OFS_PIN_MODE_LO:   regRdData_r <= pinMode_r[7:0];
                    adu_pkg::ADU_OFS_PIN_MODE_HI:   regRdData_r <= pinMode_r[15:8];
                    adu_pkg::ADU_OFS_OUTPUT_VALUE:  regRdData_r <= outValue_r;
                    adu_pkg::ADU_OFS_INPUT_LEVEL:   regRdData_r <= inLevel_r;
                    default:                        regRdData_r <= 8'h00;
                endcase
            end
        end
    end

endmodule // adu_output_update

// File: adu_output_update_asserts.sv
/*
 * Port level checker for adu_output_update, bound to every instance of it.
 * Assumes the synchronous active-low reset and one-cycle register strobes.
 */
`timescale 1ns/1ps
module adu_output_update_asserts #(
    parameter int NPINS = 8                          // Channel count.
) (
    input wire logic             clock,              // System clock.
    input wire logic             rst_n,              // Synchronous reset, active low.
    input adu_pkg::adu_reg_req_t regReq,             // Register request.
    input wire logic [7:0]       regRdData_r,        // Read data.
    input wire logic             regRdValid_r,       // Read data valid.
    input wire logic [NPINS-1:0] alertFlags,         // Alert flags.
    input wire logic [NPINS-1:0] pinOut,             // Pad drive level.
    input wire logic [NPINS-1:0] pinOutEn_n          // Pad enable, active low.
);
    // =====================================================================
    // Helpers
    // =====================================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic wrSeen_r;                                  // Any write since reset.

    // Until software writes, every pin must stay an input.
    always_ff @(posedge clock) begin
        if (!rst_n) wrSeen_r <= 1'b0;
        else if (regReq.wrEn) wrSeen_r <= 1'b1;
    end

    // No write and steady alerts: nothing can move a pin.
    sequence sQuiet;
        !regReq.wrEn && $stable(alertFlags);
    endsequence

    // =====================================================================
    // Assertions
    // =====================================================================
    AST_RESET_STATE: assert property (disable iff (1'b0) !rst_n |=>
        pinOutEn_n == '1 && pinOut == '0 && !regRdValid_r) else $error("pins not released by reset");
    AST_READ_VALID: assert property (regReq.rdEn |=> regRdValid_r)
        else $error("read not answered after one cycle");
    AST_NO_SPURIOUS_VALID: assert property (!regReq.rdEn |=> !regRdValid_r)
        else $error("read valid without a read");
    AST_UNMAPPED_ZERO: assert property (regReq.rdEn &&
        !(regReq.addr inside {[8'h40:8'h43], 8'hd1, 8'he9, 8'heb}) |=> regRdData_r == 8'h00)
        else $error("unmapped read not zero");
    AST_DATA_STANDS: assert property (!regReq.rdEn |=> $stable(regRdData_r))
        else $error("read data moved without a read");
    AST_NO_RELEASED_HIGH: assert property ((pinOut & pinOutEn_n) == '0)
        else $error("high level on a released pin");
    AST_INPUTS_UNTIL_WRITE: assert property (!wrSeen_r |-> pinOutEn_n == '1)
        else $error("pin driven before any write");
    AST_LEVEL_HELD: assert property (sQuiet [*3] |-> $stable(pinOut) && $stable(pinOutEn_n))
        else $error("pin changed without a cause");
endmodule // adu_output_update_asserts

bind adu_output_update adu_output_update_asserts #(.NPINS(NPINS)) chk_u (.clock(clock), .rst_n(rst_n),
    .regReq(regReq), .regRdData_r(regRdData_r), .regRdValid_r(regRdValid_r), .alertFlags(alertFlags),
    .pinOut(pinOut), .pinOutEn_n(pinOutEn_n));

// File: adu_pin_model.sv
/*
 * External circuit on the eight channel pins: pull-ups and optional drivers.
 * Assumes the bench only enables a driver where the device releases the pin.
 */
`timescale 1ns/1ps
module adu_pin_model (
    input  wire logic [7:0] pinOut,                  // Device drive level.
    input  wire logic [7:0] pinOutEn_n,              // Device enable, active low.
    input  wire logic [7:0] extLevel,                // External driver level.
    input  wire logic [7:0] extEn,                   // External driver enable.
    output logic      [7:0] pinIn                    // Resolved pin level.
);
    // =====================================================================
    // Wire resolution
    // =====================================================================
    // A released, undriven pin floats to the pull-up, never to a stale level.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pinOutEn_n[i]) pinIn[i] = pinOut[i];
            else if (extEn[i]) pinIn[i] = extLevel[i];
            else pinIn[i] = 1'b1;
        end
    end
endmodule // adu_pin_model

// File: adu_output_update_tb_top.sv
/*
 * Self-checking bench for adu_output_update with the pin model as far side.
 * Assumes the checker file is compiled alongside and binds itself.
 */
`timescale 1ns/1ps
module adu_output_update_tb_top;
    // =====================================================================
    // Stimulus and wiring
    // =====================================================================
    logic                  clock = 1'b0;
    logic                  rst_n = 1'b0;
    adu_pkg::adu_reg_req_t regReq = '0;
    logic [7:0]            alertFlags = '0, extLevel = '0, extEn = '0;
    logic [55:0]           otherSrcMask = '0;
    logic [7:0]            rdData, pinIn, pinOut, pinOutEn_n;
    logic                  rdValid;
    int                    errCount = 0, checked = 0;

    // Free-running 125 MHz clock.
    always #4 clock = ~clock;

    adu_output_update dut_u (.clock(clock), .rst_n(rst_n), .regReq(regReq), .regRdData_r(rdData),
        .regRdValid_r(rdValid), .alertFlags(alertFlags), .otherSrcMask(otherSrcMask), .pinIn(pinIn),
        .pinOut(pinOut), .pinOutEn_n(pinOutEn_n));
    adu_pin_model pin_u (.pinOut(pinOut), .pinOutEn_n(pinOutEn_n), .extLevel(extLevel), .extEn(extEn),
        .pinIn(pinIn));

    // =====================================================================
    // Shared tasks
    // =====================================================================
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        checked++;
        if (s !== e) begin
            errCount++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // The strobe drops on the closing edge, so the next call lets one edge pass.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regReq <= '{1'b1, 1'b0, a, d};
        @(posedge clock);
        regReq <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        regReq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clock);
        regReq <= '0;
        #1;
        chk("rdValid", 8'h01, {7'h00, rdValid});
        chk("rdData", e, rdData);
    endtask
    task automatic pins(input logic [7:0] eo, input logic [7:0] ee);
        repeat (3) @(posedge clock);
        #1;
        chk("pinOut", eo, pinOut);
        chk("pinOutEn_n", ee, pinOutEn_n);
    endtask
    task automatic fl(input logic [7:0] f, input logic [7:0] e);
        @(posedge clock);
        alertFlags <= f;
        pins(e, 8'h00);
    endtask

    // =====================================================================
    // Scenarios
    // =====================================================================
    task automatic t_reset();
        pins(8'h00, 8'hff);
        rd(adu_pkg::ADU_OFS_UPDATE_ENABLE, 8'h00);
        rd(adu_pkg::ADU_OFS_PRESET_VALUE, 8'h00);
        rd(adu_pkg::ADU_OFS_OUT7_SRC_MASK, 8'h00);
        wr(8'h77, 8'h5a);
        rd(8'h77, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_rw();
        wr(adu_pkg::ADU_OFS_UPDATE_ENABLE, 8'ha5);
        rd(adu_pkg::ADU_OFS_UPDATE_ENABLE, 8'ha5);
        wr(adu_pkg::ADU_OFS_PRESET_VALUE, 8'h5a);
        rd(adu_pkg::ADU_OFS_PRESET_VALUE, 8'h5a);
        wr(adu_pkg::ADU_OFS_OUT7_SRC_MASK, 8'h3c);
        rd(adu_pkg::ADU_OFS_OUT7_SRC_MASK, 8'h3c);
        wr(adu_pkg::ADU_OFS_UPDATE_ENABLE, 8'h00);
        $display("test access done");
    endtask
    // Pin 0 input, 1 open-drain, 2 push-pull, 3 reserved, 4 to 7 input.
    task automatic t_modes();
        wr(adu_pkg::ADU_OFS_PIN_MODE_LO, 8'he4);
        wr(adu_pkg::ADU_OFS_OUTPUT_VALUE, 8'h06);
        @(posedge clock);
        extLevel <= 8'h09;
        extEn <= 8'hf9;
        pins(8'h04, 8'hfb);
        rd(adu_pkg::ADU_OFS_INPUT_LEVEL, 8'h09);
        rd(adu_pkg::ADU_OFS_PIN_MODE_LO, 8'he4);
        wr(adu_pkg::ADU_OFS_OUTPUT_VALUE, 8'h00);
        pins(8'h00, 8'hf9);
        // Outside drivers go away before the pins turn into outputs.
        @(posedge clock);
        extEn <= 8'h00;
        $display("test modes done");
    endtask
    task automatic t_alert();
        wr(adu_pkg::ADU_OFS_PIN_MODE_LO, 8'haa);
        wr(adu_pkg::ADU_OFS_PIN_MODE_HI, 8'haa);
        wr(adu_pkg::ADU_OFS_UPDATE_ENABLE, 8'h80);
        wr(adu_pkg::ADU_OFS_PRESET_VALUE, 8'h81);
        wr(adu_pkg::ADU_OFS_OUT7_SRC_MASK, 8'h04);
        otherSrcMask <= 56'h04;
        fl(8'h08, 8'h00);
        fl(8'h00, 8'h00);
        fl(8'h04, 8'h80);
        fl(8'h00, 8'h80);
        wr(adu_pkg::ADU_OFS_OUTPUT_VALUE, 8'hff);
        wr(adu_pkg::ADU_OFS_UPDATE_ENABLE, 8'h81);
        wr(adu_pkg::ADU_OFS_PRESET_VALUE, 8'h00);
        fl(8'h04, 8'h7e);
        rd(adu_pkg::ADU_OFS_OUTPUT_VALUE, 8'h7e);
        $display("test alert done");
    endtask
    // A second reset in mid-run must return the pins, update enable, preset and output value to their reset values.
    task automatic t_rerun();
        @(posedge clock);
        alertFlags <= 8'h00;
        rst_n <= 1'b0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        pins(8'h00, 8'hff);
        rd(adu_pkg::ADU_OFS_UPDATE_ENABLE, 8'h00);
        rd(adu_pkg::ADU_OFS_PRESET_VALUE, 8'h00);
        rd(adu_pkg::ADU_OFS_OUTPUT_VALUE, 8'h00);
        $display("test rerun done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Main sequence: reset for ten cycles, then each scenario in turn.
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_rw();
        t_modes();
        t_alert();
        t_rerun();
        conclude();
    end
endmodule // adu_output_update_tb_top
